// ---- hdl/ccbg_edge_sync.sv ----
// module: two-flop synchroniser with rising edge pulse for the slow clock pin
`timescale 1ns/100ps
module ccbg_edge_sync #(
  parameter int unsigned STAGES = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // asynchronous level
  input wire logic async_in,
  // one-cycle pulse on each rising edge
  output logic rise_ff
);

  // ==========================================================================
  // synchroniser chain, stage 0 feeds stage 1 only
  logic [STAGES:0] sync_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= {sync_ff[STAGES-1:0], async_in};
    end
  end

  // ==========================================================================
  // edge detect on the settled stages
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rise_ff <= 1'h0;
    end else begin
      rise_ff <= sync_ff[STAGES-1] & ~sync_ff[STAGES];
    end
  end

endmodule

// ---- hdl/ccbg_pkg.sv ----
// package: register map, field layout, reset values and states of the core clock burst gate
// ============================================================================
// ============================================================================
package ccbg_pkg;

  // ==========================================================================
  // register map
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ==========================================================================
  // control register fields
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned WIDTH_MSB = 4;
  localparam int unsigned WIDTH_W = 5;
  localparam logic ENABLE_RESET = 1'h0;
  localparam logic [4:0] WIDTH_RESET = 5'h1F;
  localparam logic [4:0] WIDTH_FULL = 5'h1F;
  localparam logic [4:0] WIDTH_ZERO = 5'h00;

  // ==========================================================================
  // status register fields
  localparam int unsigned ST_CORE_ON_BIT = 0;
  localparam int unsigned ST_BUS_REQ_BIT = 1;
  localparam int unsigned ST_DMA_GNT_BIT = 2;
  localparam int unsigned ST_SLOT_ON_BIT = 3;
  localparam int unsigned ST_PHASE_LSB = 8;

  // ==========================================================================
  // burst period: slots 0..30 of the slow clock
  localparam logic [4:0] PHASE_ZERO = 5'h00;
  localparam logic [4:0] PHASE_STEP = 5'h01;
  localparam logic [4:0] PERIOD_LAST = 5'h1E;

  // ==========================================================================
  // reset values of the gate outputs
  localparam logic CORE_ON_RESET = 1'h1;
  localparam logic BUS_REQ_RESET = 1'h0;

  // ==========================================================================
  // gate sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_REQ,
    ST_OFF
  } ccbg_state_e;

endpackage

// ---- hdl/ccbg_top.sv ----
// module: core clock burst gate with APB control and status registers
`timescale 1ns/100ps
module ccbg_top (
  // system clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // slow clock pin, sets the burst period
  input wire logic slow_32k_clock,
  // unmasked wake-up event from interrupt logic
  input wire logic wake_event,
  // bus arbitration with the core and the dma controller
  input wire logic bus_grant,
  input wire logic dma_busy,
  output logic bus_request,
  output logic dma_bus_grant,
  // enable for the glitch-free core clock gate cell
  output logic core_clock_enable
);

  // ==========================================================================
  // address decode shared by read and write paths
  function automatic logic reg_hit(input logic [31:0] addr, input logic [11:0] off);
    reg_hit = (addr[ccbg_pkg::APB_AW-1:0] == off);
  endfunction

  // ==========================================================================
  // declarations
  logic setup_w;
  logic access_w;
  logic wr_ctrl_w;
  logic mapped_w;
  logic slow_tick_w;
  logic slot_on_w;
  logic resume_w;
  logic [4:0] wdata_width_w;
  logic [31:0] ctrl_word_w;
  logic [31:0] status_word_w;
  logic [31:0] read_word_w;
  logic burst_gating_enable_ff;
  logic [4:0] width_ff;
  logic [4:0] phase_ff;
  logic [4:0] nxt_phase;
  ccbg_pkg::ccbg_state_e state_ff;
  ccbg_pkg::ccbg_state_e nxt_state;
  logic core_on_ff;
  logic core_en_neg_ff;
  logic bus_req_ff;
  logic dma_gnt_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;

  // ==========================================================================
  // apb phase decode
  assign setup_w = psel & ~penable;
  assign access_w = psel & penable & pready_ff;
  assign mapped_w = reg_hit(paddr, ccbg_pkg::CTRL_OFFSET)
                  | reg_hit(paddr, ccbg_pkg::STATUS_OFFSET);
  assign wr_ctrl_w = access_w & pwrite & reg_hit(paddr, ccbg_pkg::CTRL_OFFSET);
  assign wdata_width_w = pwdata[ccbg_pkg::WIDTH_MSB:0];

  // ready one cycle after setup, so every access has no wait state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pready_ff <= 1'h0;
    end else begin
      pready_ff <= setup_w;
    end
  end

  // error answer for unmapped offsets, valid with ready
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pslverr_ff <= 1'h0;
    end else begin
      pslverr_ff <= setup_w & ~mapped_w;
    end
  end

  // read data captured at setup, held until the next setup
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= ccbg_pkg::ZERO_WORD;
    end else if (setup_w) begin
      prdata_ff <= pwrite ? ccbg_pkg::ZERO_WORD : read_word_w;
    end
  end

  // ==========================================================================
  // read words; reserved bits read as zero
  always_comb begin
    ctrl_word_w = ccbg_pkg::ZERO_WORD;
    ctrl_word_w[ccbg_pkg::ENABLE_BIT] = burst_gating_enable_ff;
    ctrl_word_w[ccbg_pkg::WIDTH_MSB:0] = width_ff;
  end

  always_comb begin
    status_word_w = ccbg_pkg::ZERO_WORD;
    status_word_w[ccbg_pkg::ST_CORE_ON_BIT] = core_on_ff;
    status_word_w[ccbg_pkg::ST_BUS_REQ_BIT] = bus_req_ff;
    status_word_w[ccbg_pkg::ST_DMA_GNT_BIT] = dma_gnt_ff;
    status_word_w[ccbg_pkg::ST_SLOT_ON_BIT] = slot_on_w;
    status_word_w[ccbg_pkg::ST_PHASE_LSB +: ccbg_pkg::WIDTH_W] = phase_ff;
  end

  // read mux by offset
  always_comb begin
    if (reg_hit(paddr, ccbg_pkg::CTRL_OFFSET)) begin
      read_word_w = ctrl_word_w;
    end else if (reg_hit(paddr, ccbg_pkg::STATUS_OFFSET)) begin
      read_word_w = status_word_w;
    end else begin
      read_word_w = ccbg_pkg::ZERO_WORD;
    end
  end

  // ==========================================================================
  // enable bit: reset low, wake-up clear of a set enable beats a software write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      burst_gating_enable_ff <= ccbg_pkg::ENABLE_RESET;
    end else if (wake_event && burst_gating_enable_ff) begin
      burst_gating_enable_ff <= 1'h0;
    end else if (wr_ctrl_w) begin
      burst_gating_enable_ff <= pwdata[ccbg_pkg::ENABLE_BIT];
    end
  end

  // width field: written only by software, never by enable or wake-up
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      width_ff <= ccbg_pkg::WIDTH_RESET;
    end else if (wr_ctrl_w) begin
      width_ff <= wdata_width_w;
    end
  end

  // ==========================================================================
  // slow clock pin into the system clock domain
  ccbg_edge_sync #(
    .STAGES(2)
  ) ccbg_edge_sync_inst (
    .clock(clock),
    .nrst(nrst),
    .async_in(slow_32k_clock),
    .rise_ff(slow_tick_w)
  );

  // period phase: 31 slow ticks, held at slot 0 while disabled
  always_comb begin
    if (!burst_gating_enable_ff) begin
      nxt_phase = ccbg_pkg::PHASE_ZERO;
    end else if (!slow_tick_w) begin
      nxt_phase = phase_ff;
    end else if (phase_ff == ccbg_pkg::PERIOD_LAST) begin
      nxt_phase = ccbg_pkg::PHASE_ZERO;
    end else begin
      nxt_phase = phase_ff + ccbg_pkg::PHASE_STEP;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= ccbg_pkg::PHASE_ZERO;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // pulse-width comparator: on for the first width slots of the period
  assign slot_on_w = (phase_ff < width_ff);

  // wake-up, disable or a new on slot all bring the clock back
  assign resume_w = ~burst_gating_enable_ff | wake_event | slot_on_w;

  // ==========================================================================
  // gate sequencer: run, request bus, clock off
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ccbg_pkg::ST_RUN: begin
        if (!resume_w) begin
          nxt_state = ccbg_pkg::ST_REQ;
        end
      end
      ccbg_pkg::ST_REQ: begin
        if (resume_w) begin
          nxt_state = ccbg_pkg::ST_RUN;
        end else if (bus_grant) begin
          nxt_state = ccbg_pkg::ST_OFF;
        end
      end
      ccbg_pkg::ST_OFF: begin
        if (resume_w && !dma_busy) begin
          nxt_state = ccbg_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = ccbg_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ccbg_pkg::ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // core clock on in run and request, off only after grant
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      core_on_ff <= ccbg_pkg::CORE_ON_RESET;
    end else begin
      core_on_ff <= (nxt_state != ccbg_pkg::ST_OFF);
    end
  end

  // bus held from the request until the clock is back
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_req_ff <= ccbg_pkg::BUS_REQ_RESET;
    end else begin
      bus_req_ff <= (nxt_state != ccbg_pkg::ST_RUN);
    end
  end

  // dma owns the bus while the core clock is stopped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dma_gnt_ff <= ccbg_pkg::BUS_REQ_RESET;
    end else begin
      dma_gnt_ff <= (nxt_state == ccbg_pkg::ST_OFF);
    end
  end

  // gate enable moves on the falling edge, while the clock is low
  always_ff @(negedge clock or negedge nrst) begin
    if (!nrst) begin
      core_en_neg_ff <= ccbg_pkg::CORE_ON_RESET;
    end else begin
      core_en_neg_ff <= core_on_ff;
    end
  end

  // ==========================================================================
  // outputs, each straight from a flop
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign bus_request = bus_req_ff;
  assign dma_bus_grant = dma_gnt_ff;
  assign core_clock_enable = core_en_neg_ff;

  // ==========================================================================
  // assertions and covers
  default clocking ast_cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  AST_APB_READY: assert property ( // apb
    (psel && !penable) |=> (pready_ff && !$past(pready_ff))
  ) else $error("ready did not follow setup by one cycle");

  AST_DISABLED_RUNS: assert property (
    (!burst_gating_enable_ff && state_ff != ccbg_pkg::ST_OFF) |=> core_on_ff ##1 core_en_neg_ff
  ) else $error("core clock stopped while gating disabled");

  AST_WAKE_CLEARS: assert property (
    (wake_event && burst_gating_enable_ff) |=> !burst_gating_enable_ff
  ) else $error("wake-up did not clear the enable");

  AST_WIDTH_WRITE: assert property (
    wr_ctrl_w |=> (width_ff == $past(wdata_width_w))
  ) else $error("width write lost or altered by enable bit");

  AST_WIDTH_KEPT: assert property (
    (wake_event && burst_gating_enable_ff && !wr_ctrl_w) |=> $stable(width_ff)
  ) else $error("wake-up changed the width field");

  AST_FULL_ON: assert property (
    (burst_gating_enable_ff && width_ff == ccbg_pkg::WIDTH_FULL
      && state_ff == ccbg_pkg::ST_RUN) |=> (state_ff == ccbg_pkg::ST_RUN && core_on_ff)
  ) else $error("full width code gated the clock");

  AST_DOZE: assert property (
    (burst_gating_enable_ff && width_ff == ccbg_pkg::WIDTH_ZERO && !wake_event
      && state_ff == ccbg_pkg::ST_RUN) |=> (state_ff == ccbg_pkg::ST_REQ && bus_req_ff)
  ) else $error("zero width did not start stopping the clock");

  AST_PERIOD_WRAP: assert property (
    (slow_tick_w && burst_gating_enable_ff && phase_ff == ccbg_pkg::PERIOD_LAST)
      |=> (phase_ff == ccbg_pkg::PHASE_ZERO)
  ) else $error("burst period is not 31 slow cycles");

  AST_STOP_AFTER_GRANT: assert property (
    $fell(core_on_ff) |-> ($past(bus_grant) && $past(bus_req_ff) && dma_gnt_ff)
  ) else $error("core clock stopped without bus grant");

  AST_DMA_FIRST: assert property (
    (state_ff == ccbg_pkg::ST_OFF && dma_busy) |=> !core_on_ff
  ) else $error("clock restored during dma access");

  AST_WAKE_FAST: assert property (
    (state_ff == ccbg_pkg::ST_OFF && wake_event && !dma_busy)
      |=> (core_on_ff && !dma_gnt_ff) ##1 core_en_neg_ff
  ) else $error("wake-up did not restore the clock at once");

  AST_REQ_ABORT: assert property (
    (state_ff == ccbg_pkg::ST_REQ && resume_w)
      |=> (state_ff == ccbg_pkg::ST_RUN && !bus_req_ff)
  ) else $error("resume during request kept the bus request");

  AST_UNMAPPED_ERR: assert property ( // apb
    (psel && !penable && !mapped_w)
      |=> (pready_ff && pslverr_ff && prdata_ff == ccbg_pkg::ZERO_WORD)
  ) else $error("unmapped offset not answered with an error");

  COV_DOZE_ENTERED: cover property (
    (width_ff == ccbg_pkg::WIDTH_ZERO) && $rose(dma_gnt_ff)
  );

  COV_WAKE_FROM_OFF: cover property (
    (state_ff == ccbg_pkg::ST_OFF) && wake_event ##1 core_on_ff
  );

  COV_BURST_CYCLE: cover property (
    $fell(core_on_ff) ##[1:1000] $rose(core_on_ff)
  );

  COV_REQ_ABORT: cover property (
    (state_ff == ccbg_pkg::ST_REQ) ##1 (state_ff == ccbg_pkg::ST_RUN)
  );

endmodule

// ---- sim/ccbg_arb_model.sv ----
// model: core bus grant and dma controller on the far side of the burst gate
`timescale 1ns/100ps
module ccbg_arb_model (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // scenario controls from the bench
  input wire logic [3:0] grant_delay,
  input wire logic dma_hold,
  // arbitration wires
  input wire logic bus_request,
  input wire logic dma_bus_grant,
  output logic bus_grant,
  output logic dma_busy
);
  logic [3:0] wait_ff;

  // core finishes its bus cycle after grant_delay edges, then grants the bus
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_ff <= 4'h0;
      bus_grant <= 1'h0;
    end else if (bus_request !== 1'h1) begin
      wait_ff <= 4'h0;
      bus_grant <= 1'h0;
    end else if (wait_ff >= grant_delay) begin
      bus_grant <= 1'h1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end

  // a dma access only runs while the dma holds the bus, and is never cut short
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dma_busy <= 1'h0;
    end else begin
      dma_busy <= dma_hold & dma_bus_grant;
    end
  end
endmodule

// ---- sim/ccbg_top_tb.sv ----
// testbench: core clock burst gate driven over apb against a bus arbitration model
`timescale 1ns/100ps
module ccbg_top_tb;
  logic clock, nrst, psel, penable, pwrite, slow_32k_clock, wake_event, dma_hold;
  logic [31:0] paddr, pwdata, prdata;
  logic pready, pslverr, bus_grant, dma_busy, bus_request, dma_bus_grant, core_clock_enable;
  logic [3:0] grant_delay;
  int fail_count, cmp_count, cyc;

  // ==========================================================================
  // design and far side
  ccbg_top ccbg_top_inst (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slow_32k_clock(slow_32k_clock), .wake_event(wake_event),
    .bus_grant(bus_grant), .dma_busy(dma_busy), .bus_request(bus_request),
    .dma_bus_grant(dma_bus_grant), .core_clock_enable(core_clock_enable));
  ccbg_arb_model ccbg_arb_model_inst (.clock(clock), .nrst(nrst), .grant_delay(grant_delay),
    .dma_hold(dma_hold), .bus_request(bus_request), .dma_bus_grant(dma_bus_grant),
    .bus_grant(bus_grant), .dma_busy(dma_busy));

  // ==========================================================================
  // clocks: system at 100 MHz, slow clock shortened to 20 system cycles
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  initial begin
    slow_32k_clock = 1'h0;
    forever #100 slow_32k_clock = ~slow_32k_clock;
  end

  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // counted on-time may carry a few cycles of handshake latency
  task automatic chk_near(input string what, input int exp, input int got);
    cmp_count++;
    if (got < exp - 4 || got > exp + 6) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, addr, d, r, e);
  endtask

  task automatic rdc(input string what, input logic [31:0] addr, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'h0, addr, 32'h0, r, e);
    chk(what, exp, r);
  endtask

  // wait a bounded time for the core clock enable to reach a level
  task automatic wait_core(input string what, input logic lvl, input int lim);
    int n;
    n = 0;
    while (core_clock_enable !== lvl && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk(what, {31'h0, lvl}, {31'h0, core_clock_enable});
  endtask

  task automatic count_on(input int len, output int on);
    on = 0;
    repeat (len) begin
      @(posedge clock);
      if (core_clock_enable === 1'h1) on++;
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    int n;
    chk("core_on_rst", 32'h1, {31'h0, core_clock_enable});
    rdc("ctrl_rst", 32'h0, 32'h1F);
    rdc("status_rst", 32'h4, 32'h9);
    apb(1'h0, 32'h8, 32'h0, r, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    count_on(300, n);
    chk("free_run", 32'd300, n);
    $display("test reset done");
  endtask

  task automatic t_doze(input logic [3:0] dly);
    int n;
    grant_delay <= dly;
    wr(32'h0, 32'h80);
    wait_core("gated", 1'h0, 40);
    chk("bus_req", 32'h1, {31'h0, bus_request});
    chk("dma_gnt", 32'h1, {31'h0, dma_bus_grant});
    count_on(200, n);
    chk("doze_on", 32'h0, n);
    rdc("ctrl_doze", 32'h0, 32'h80);
    wake_event <= 1'h1;
    wait_core("woke", 1'h1, 3);
    wake_event <= 1'h0;
    chk("req_drop", 32'h0, {31'h0, bus_request});
    rdc("ctrl_woke", 32'h0, 32'h0);
    $display("test doze done");
  endtask

  task automatic t_dma;
    int n;
    grant_delay <= 4'h5;
    wr(32'h0, 32'h80);
    wait_core("gated_dma", 1'h0, 40);
    dma_hold <= 1'h1;
    repeat (2) @(posedge clock);
    wake_event <= 1'h1;
    count_on(20, n);
    chk("dma_first", 32'h0, n);
    dma_hold <= 1'h0;
    wait_core("dma_done", 1'h1, 5);
    wake_event <= 1'h0;
    $display("test dma done");
  endtask

  // wake-up while the request waits for grant; status writes are ignored
  task automatic t_abort;
    int n;
    grant_delay <= 4'h7;
    wr(32'h0, 32'h80);
    repeat (2) @(posedge clock);
    chk("abort_req", 32'h1, {31'h0, bus_request});
    wake_event <= 1'h1;
    @(posedge clock);
    wake_event <= 1'h0;
    count_on(20, n);
    chk("abort_on", 32'd20, n);
    chk("abort_req_drop", 32'h0, {31'h0, bus_request});
    chk("abort_dma", 32'h0, {31'h0, dma_bus_grant});
    wr(32'h4, 32'hFFFF_FFFF);
    rdc("ctrl_abort", 32'h0, 32'h0);
    $display("test abort done");
  endtask

  // reset in mid-run while the core clock is stopped
  task automatic t_rst_mid;
    grant_delay <= 4'h0;
    wr(32'h0, 32'h80);
    wait_core("gated_rst", 1'h0, 40);
    nrst <= 1'h0;
    repeat (3) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    chk("core_on_mid_rst", 32'h1, {31'h0, core_clock_enable});
    chk("req_mid_rst", 32'h0, {31'h0, bus_request});
    rdc("ctrl_mid_rst", 32'h0, 32'h1F);
    $display("test mid reset done");
  endtask

  task automatic t_burst(input logic [4:0] w);
    int n;
    grant_delay <= 4'h0;
    wr(32'h0, {24'h0, 3'h4, w});
    repeat (620) @(posedge clock);
    count_on(620, n);
    chk_near("burst_on", w * 20, n);
    wr(32'h0, {27'h0, w});
    wait_core("burst_off", 1'h1, 10);
    rdc("width_kept", 32'h0, {27'h0, w});
    $display("test burst %0d done", w);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    nrst = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    wake_event = 1'h0;
    dma_hold = 1'h0;
    grant_delay = 4'h0;
    repeat (5) @(posedge clock);
    nrst <= 1'h1;
    @(posedge clock);
    t_reset();
    t_doze(4'h0);
    t_doze(4'h7);
    t_dma();
    t_abort();
    t_rst_mid();
    t_burst(5'h01);
    t_burst(5'h03);
    t_burst(5'h10);
    t_burst(5'h1F);
    print_verdict();
  end
endmodule
